// File: design/sipo_pkg.sv
package sipo_pkg;
    // width of the shift and storage stages
    localparam int SIPO_WIDTH = 8;
    // values after reset; the shift value also after clear
    localparam logic [7:0] SIPO_SHIFT_RST = 8'h00;
    localparam logic [7:0] SIPO_LATCH_RST = 8'h00;
    // pin inputs pass this many flops before use
    localparam int SIPO_SYNC_STAGES = 2;

    // host-side pin group sampled on clk_sys
    typedef struct packed {
        logic serial_in;
        logic latch_clock;
        logic shift_clear_n;
        logic out_enable_n;
    } sipo_pins_t;

    // idle level of each host pin; the synchronised pins come out of reset at this
    localparam sipo_pins_t SIPO_PINS_IDLE = '{serial_in:     1'b0,
                                              latch_clock:   1'b0,
                                              shift_clear_n: 1'b1,
                                              out_enable_n:  1'b1};

    // parallel output pin group
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } sipo_par_t;
endpackage

// File: design/sipo_sync.sv
module sipo_sync
    import sipo_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // two-flop synchroniser; meta feeds only q
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// File: design/sipo_latch.sv
module sipo_latch
    import sipo_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       shift_clock,
    input  wire logic       serial_in,
    input  wire logic       latch_clock,
    input  wire logic       shift_clear_n,
    input  wire logic       out_enable_n,
    output logic            serial_out,
    output logic      [7:0] par_out,
    output logic      [7:0] par_out_oe
);
    // shift domain: clear is direct, asynchronous and active low
    logic [SIPO_WIDTH-1:0] shift_q;
    logic                  link_rst_n;

    assign link_rst_n = shift_clear_n & ~rst;

    // serial shift on the link's own clock
    always_ff @(posedge shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift_q <= SIPO_SHIFT_RST;
        end else begin
            shift_q <= {shift_q[SIPO_WIDTH-2:0], serial_in};
        end
    end

    // cascade output straight off the last stage
    assign serial_out = shift_q[SIPO_WIDTH-1];

    // shift contents cross to clk_sys: two flops per bit
    logic [SIPO_WIDTH-1:0] shift_meta;
    logic [SIPO_WIDTH-1:0] shift_sys;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_meta <= SIPO_SHIFT_RST;
            shift_sys  <= SIPO_SHIFT_RST;
        end else begin
            shift_meta <= shift_q;
            shift_sys  <= shift_meta;
        end
    end

    // control pins are synchronised before any clk_sys logic looks at them
    // the synchroniser resets to zero, so each pin is flipped against
    // its idle level around it; otherwise the active-low enable would
    // read as asserted for two cycles after reset and drive the pins
    sipo_pins_t pins_raw;
    sipo_pins_t pins_flip;
    sipo_pins_t pins_seen;
    sipo_pins_t pins;

    assign pins_raw = '{serial_in:     serial_in,
                        latch_clock:   latch_clock,
                        shift_clear_n: shift_clear_n,
                        out_enable_n:  out_enable_n};

    assign pins_flip = pins_raw ^ SIPO_PINS_IDLE;

    sipo_sync #(
        .WIDTH ($bits(sipo_pins_t))
    ) u_sync (
        .clk (clk_sys),
        .rst (rst),
        .d   (pins_flip),
        .q   (pins_seen)
    );

    // undo the flip, so reset leaves every pin at its idle level
    assign pins = pins_seen ^ SIPO_PINS_IDLE;

    // rising edge of the latch clock, found on the synchronised copy
    logic latch_prev;
    logic latch_rise;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            latch_prev <= 1'b0;
        end else begin
            latch_prev <= pins.latch_clock;
        end
    end

    assign latch_rise = pins.latch_clock & ~latch_prev;

    // storage register; clear and shift activity do not touch it
    // limitation: host must let shift contents settle before latching,
    // since the word crosses bit by bit and is not a coherent snapshot
    logic [SIPO_WIDTH-1:0] store_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            store_q <= SIPO_LATCH_RST;
        end else if (latch_rise && pins.shift_clear_n) begin
            store_q <= shift_sys;
        end
    end

    // parallel outputs, floated while enable is high
    sipo_par_t par;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            par <= '{data: SIPO_LATCH_RST, oe: 8'h00};
        end else begin
            par.data <= store_q;
            par.oe   <= {SIPO_WIDTH{~pins.out_enable_n}};
        end
    end

    assign par_out    = par.data;
    assign par_out_oe = par.oe;

    // assertions on the system clock
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_latch_edge;
        latch_rise && pins.shift_clear_n;
    endsequence

    a_latch_copy: assert property (s_latch_edge |=> store_q == $past(shift_sys))
        else $error("storage did not copy shift contents");
    a_store_hold: assert property (!(latch_rise && pins.shift_clear_n)
            |=> $stable(store_q))
        else $error("storage changed without a latch edge");
    a_out_float: assert property (pins.out_enable_n |=> par_out_oe == 8'h00)
        else $error("outputs driven while disabled");
    a_out_drive: assert property (!pins.out_enable_n
            |=> par_out_oe == 8'hff && par_out == $past(store_q))
        else $error("outputs not driving storage contents");
    a_path_delay: assert property (s_latch_edge ##1 1 |=> par_out == $past(store_q))
        else $error("output lags storage wrongly");
    a_serial_tap: assert property (serial_out == shift_q[SIPO_WIDTH-1])
        else $error("serial output not last stage");
    a_clear_zero: assert property (!shift_clear_n |-> serial_out == 1'b0)
        else $error("serial output not zero under clear");
    a_edge_only: assert property (!latch_rise |=> $stable(store_q))
        else $error("storage moved without edge");

    // link-domain checks: the two shift checks run on the link clock, and the clear stops them at once
    // since a cleared register owes nothing to the last sampled bit
    sequence s_link_live;
        link_rst_n;
    endsequence

    // first stage takes the serial bit seen at the rising edge
    a_shift_entry: assert property (@(posedge shift_clock)
            disable iff (!link_rst_n)
            s_link_live |=> shift_q[0] == $past(serial_in))
        else $error("first stage missed the serial bit");

    // every other stage takes its neighbour's old value
    a_shift_move: assert property (@(posedge shift_clock)
            disable iff (!link_rst_n)
            s_link_live |=> shift_q[SIPO_WIDTH-1:1]
                == $past(shift_q[SIPO_WIDTH-2:0]))
        else $error("stages did not move up by one");

    // clear holds the whole shift register at zero, not only the tap
    a_shift_clear: assert property (!link_rst_n
            |-> shift_q == SIPO_SHIFT_RST)
        else $error("shift register not zero under clear");

    // every enable bit moves together; a split word means a bad fan-out
    a_oe_uniform: assert property (par_out_oe == 8'h00
            || par_out_oe == 8'hff)
        else $error("output enables disagree");

    // a latch edge that meets an active clear must be ignored
    sequence s_latch_refused;
        latch_rise && !pins.shift_clear_n;
    endsequence

    a_latch_refuse: assert property (s_latch_refused
            |=> $stable(store_q))
        else $error("storage moved on a refused latch");

    // store first, then the pins one cycle later
    sequence s_store_then_out;
        store_q == $past(shift_sys)
        ##1 par_out == $past(store_q);
    endsequence

    a_latch_steps: assert property (s_latch_edge
            |=> s_store_then_out)
        else $error("latch path out of step");

    // outputs only drive when the enable pin was seen low
    a_drive_enable: assert property (par_out_oe == 8'hff
            |-> $past(!pins.out_enable_n))
        else $error("outputs drive without enable");

    // the pins never float while enable was seen low
    a_float_enable: assert property (par_out_oe == 8'h00
            |-> $past(pins.out_enable_n))
        else $error("outputs float with enable low");

    // limitation: these checks watch the synchronised copy, so a pin
    // pulse that spans no rising clk_sys edge is neither seen nor checked
endmodule

// File: tb/sipo_host.sv
// host side: shift clock runs only inside a frame
module sipo_host (
    input  wire logic clk_sys,
    output logic      shift_clock,
    output logic      serial_in,
    output logic      latch_clock
);
    timeunit 1ns;
    timeprecision 100ps;

    // all host lines idle low at time zero
    initial begin
        shift_clock = 1'b0;
        serial_in = 1'b0;
        latch_clock = 1'b0;
    end

    // msb first, so the first bit lands in the oldest stage
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            serial_in = b[i];
            #7.5 shift_clock = 1'b1;
            #7.5 shift_clock = 1'b0;
        end
        serial_in = ~b[0]; // released line must not show a stale bit
    endtask

    // settle 3 cycles, then 3 high and 3 low so the sync sees both levels
    task automatic pulse_latch();
        repeat (3) @(posedge clk_sys);
        #1 latch_clock = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 latch_clock = 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule

// File: tb/tb.sv
module tb;
    import sipo_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys, rst, shift_clock, serial_in, latch_clock;
    logic       shift_clear_n, out_enable_n, serial_out;
    logic [7:0] par_out, par_out_oe, prev;
    int         n_mismatch = 0;
    int         comparisons = 0;
    // rows: byte sent in the upper half, latched value in the lower half
    logic [15:0] rows [4] = '{16'ha5a5, 16'h0101, 16'h8080, 16'hffff};

    sipo_host u_host (.clk_sys(clk_sys), .shift_clock(shift_clock),
        .serial_in(serial_in), .latch_clock(latch_clock));
    sipo_latch u_dut (.clk_sys(clk_sys), .rst(rst),
        .shift_clock(shift_clock), .serial_in(serial_in),
        .latch_clock(latch_clock), .shift_clear_n(shift_clear_n),
        .out_enable_n(out_enable_n), .serial_out(serial_out),
        .par_out(par_out), .par_out_oe(par_out_oe));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // whole run is a few microseconds
    initial begin
        #50us;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        shift_clear_n = 1'b1;
        out_enable_n = 1'b0;
        prev = 8'h00;
        repeat (6) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        check(par_out_oe, 8'hff);
        check(par_out, 8'h00);
        foreach (rows[i]) begin
            u_host.send(rows[i][15:8]);
            check({7'h00, serial_out}, {7'h00, rows[i][15]});
            check(par_out, prev);
            u_host.pulse_latch();
            check(par_out, rows[i][7:0]);
            prev = rows[i][7:0];
        end
        // clear after a frame, before its latch: shifts and latches are refused, storage kept
        u_host.send(8'h3c);
        @(posedge clk_sys) #1 shift_clear_n = 1'b0;
        #1 check({7'h00, serial_out}, 8'h00);
        u_host.send(8'hff);
        check({7'h00, serial_out}, 8'h00);
        u_host.pulse_latch();
        check(par_out, 8'hff);
        @(posedge clk_sys) #1 shift_clear_n = 1'b1;
        u_host.pulse_latch();
        check(par_out, 8'h00);
        @(posedge clk_sys) #1 out_enable_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        check(par_out_oe, 8'h00);
        // mid-run reset with outputs disabled: nothing may drive
        u_host.send(8'h80);
        check({7'h00, serial_out}, 8'h01);
        u_host.pulse_latch();
        check(par_out, 8'h80);
        @(posedge clk_sys) #1 rst = 1'b1;
        #1 check({7'h00, serial_out}, 8'h00);
        check(par_out, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (2) begin
            @(posedge clk_sys) #1 check(par_out_oe, 8'h00);
        end
        out_enable_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        check(par_out_oe, 8'hff);
        end_of_test();
    end
endmodule
